/* shared/mise_pkg.sv */
package mise_pkg;

  // Widths
  localparam int INSTR_W  = 12;               // Instruction word
  localparam int DATA_W   = 8;                // Data path
  localparam int PC_W     = 11;               // Program counter
  localparam int FADDR_W  = 5;                // File address
  localparam int BIT_W    = 3;                // Bit index
  localparam int RADDR_W  = 6;                // Register port address
  localparam int PAGE_W   = 2;                // Page select
  localparam int STK_DEPTH = 2;               // Hardware stack levels
  localparam int PRE_W    = 8;                // Prescaler width
  localparam int FILE_N   = 32;               // File registers

  // Instruction field positions
  localparam int DEST_POS  = 5;               // Destination select
  localparam int FADDR_LSB = 0;               // File address
  localparam int BIT_LSB   = 5;               // Bit index
  localparam int LIT_LSB   = 0;               // Immediate

  // Opcode masks and matches
  localparam logic [11:0] AND_MASK  = 12'hFC0;
  localparam logic [11:0] AND_MATCH = 12'h140;
  localparam logic [11:0] INV_MASK  = 12'hFC0;
  localparam logic [11:0] INV_MATCH = 12'h240;
  localparam logic [11:0] CLEAR_FILE_REG_MASK = 12'hFE0;
  localparam logic [11:0] CLEAR_FILE_REG_MATCH = 12'h060;
  localparam logic [11:0] CLEAR_ACCUMULATOR_WORD = 12'h040;
  localparam logic [11:0] KICK_WORD = 12'h004;
  localparam logic [11:0] NIB_MASK  = 12'hF00;
  localparam logic [11:0] BTC_MATCH = 12'h600;
  localparam logic [11:0] BTS_MATCH = 12'h700;
  localparam logic [11:0] CALL_MATCH = 12'h900;

  // Register port map
  localparam logic [5:0] REG_ACCUM    = 6'h00;
  localparam logic [5:0] REG_STATUS   = 6'h01;
  localparam logic [5:0] REG_OPTION   = 6'h02;
  localparam logic [5:0] REG_PC_LO    = 6'h03;
  localparam logic [5:0] REG_PC_HI    = 6'h04;
  localparam logic [5:0] REG_WDOG     = 6'h05;
  localparam logic [5:0] REG_STK_LO   = 6'h06;
  localparam logic [5:0] REG_STK_HI   = 6'h07;
  localparam logic [5:0] FILE_MASK    = 6'h20;
  localparam logic [5:0] FILE_BASE    = 6'h20;

  // Status and option fields
  localparam int ST_NULL     = 2;
  localparam int ST_SLEEP    = 3;
  localparam int ST_EXPIRY   = 4;
  localparam int ST_PAGE_LSB = 5;
  localparam int OPT_TO_WDOG = 3;

  // Reset values
  localparam logic [7:0]  ACCUM_RST  = 8'h00;
  localparam logic [7:0]  STATUS_RST = 8'h18;
  localparam logic [7:0]  OPTION_RST = 8'h08;
  localparam logic [10:0] PC_RST     = 11'h000;
  localparam logic [7:0]  ZERO8      = 8'h00;

  // Executed operation kinds
  typedef enum {
    OP_AND, OP_INVERT, OP_CLEAR_FILE_REG, OP_CLEAR_ACCUMULATOR, OP_KICK, OP_BTC, OP_BTS, OP_CALL, OP_OTHER
  } mise_op_e;

  // Instruction word to operation kind
  function automatic mise_op_e mise_decode(input logic [11:0] w);
    if ((w & AND_MASK) == AND_MATCH) return OP_AND;
    if ((w & INV_MASK) == INV_MATCH) return OP_INVERT;
    if ((w & CLEAR_FILE_REG_MASK) == CLEAR_FILE_REG_MATCH) return OP_CLEAR_FILE_REG;
    if (w == CLEAR_ACCUMULATOR_WORD) return OP_CLEAR_ACCUMULATOR;
    if (w == KICK_WORD) return OP_KICK;
    if ((w & NIB_MASK) == BTC_MATCH) return OP_BTC;
    if ((w & NIB_MASK) == BTS_MATCH) return OP_BTS;
    if ((w & NIB_MASK) == CALL_MATCH) return OP_CALL;
    return OP_OTHER;
  endfunction : mise_decode

endpackage : mise_pkg

/* hdl/mise_stack.sv */
`timescale 1ns/1ps
`default_nettype none
module mise_stack (
  input  wire logic                       mclk,      // Clock
  input  wire logic                       rst,       // Sync reset
  input  wire logic                       push,      // Push pulse
  input  wire logic [mise_pkg::PC_W-1:0]  push_addr, // Return address
  output logic      [mise_pkg::PC_W-1:0]  top        // Top of stack
);

  ////////////////////////////////////////////////////////////////
  logic [mise_pkg::PC_W-1:0] ent_ff  [mise_pkg::STK_DEPTH];  // Stack levels
  logic [mise_pkg::PC_W-1:0] nxt_ent [mise_pkg::STK_DEPTH];  // Next levels

  // Push shifts every level down by one; oldest falls off
  genvar g;
  generate
    for (g = 0; g < mise_pkg::STK_DEPTH; g++) begin : g_lvl
      if (g == 0) begin : g_top
        assign nxt_ent[g] = push ? push_addr : ent_ff[g];
      end else begin : g_low
        assign nxt_ent[g] = push ? ent_ff[g-1] : ent_ff[g];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Register levels
  always_ff @(posedge mclk) begin
    for (int i = 0; i < mise_pkg::STK_DEPTH; i++) begin
      ent_ff[i] <= rst ? mise_pkg::PC_RST : nxt_ent[i];
    end
  end

  assign top = ent_ff[0];

endmodule : mise_stack
`default_nettype wire

/* hdl/mise_wdog.sv */
`timescale 1ns/1ps
`default_nettype none
module mise_wdog (
  input  wire logic                        mclk,    // Clock
  input  wire logic                        rst,     // Sync reset
  input  wire logic                        kick,    // Kick pulse
  input  wire logic                        to_wdog, // Prescaler on watchdog
  output logic      [mise_pkg::DATA_W-1:0] count,   // Watchdog count
  output logic                             expire   // Overflow pulse
);

  ////////////////////////////////////////////////////////////////
  logic [mise_pkg::PRE_W-1:0]  pre_ff, nxt_pre;   // Shared prescaler
  logic [mise_pkg::DATA_W-1:0] cnt_ff, nxt_cnt;   // Watchdog counter
  logic                        exp_ff, nxt_exp;   // Overflow pulse
  logic                        tick;              // Counter advance

  // Counter steps on prescaler wrap, or every cycle if unassigned
  assign tick = to_wdog ? (pre_ff == {mise_pkg::PRE_W{1'b1}}) : 1'b1;

  // Next state
  always_comb begin
    nxt_pre = pre_ff + 8'h01;
    nxt_cnt = cnt_ff;
    nxt_exp = 1'b0;
    if (kick && to_wdog) begin
      nxt_pre = mise_pkg::ZERO8;
    end
    if (kick) begin
      nxt_cnt = mise_pkg::ZERO8;
    end else if (tick) begin
      nxt_cnt = cnt_ff + 8'h01;
      nxt_exp = (cnt_ff == {mise_pkg::DATA_W{1'b1}});
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register state
  always_ff @(posedge mclk) begin
    if (rst) begin
      pre_ff <= mise_pkg::ZERO8;
      cnt_ff <= mise_pkg::ZERO8;
      exp_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      cnt_ff <= nxt_cnt;
      exp_ff <= nxt_exp;
    end
  end

  assign count  = cnt_ff;
  assign expire = exp_ff;

endmodule : mise_wdog
`default_nettype wire

/* hdl/mise_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module mise_exec (
  input  wire logic                         mclk,        // Clock, 25 MHz
  input  wire logic                         rst,         // Sync reset
  input  wire logic [mise_pkg::INSTR_W-1:0] instr_word,  // Fetched word
  input  wire logic                         instr_valid, // Word present
  input  wire logic [mise_pkg::RADDR_W-1:0] reg_addr,    // Port address
  input  wire logic [mise_pkg::DATA_W-1:0]  reg_wdata,   // Port write data
  input  wire logic                         reg_wr,      // Write strobe
  input  wire logic                         reg_rd,      // Read strobe
  output logic      [mise_pkg::DATA_W-1:0]  reg_rdata,   // Read data
  output logic      [mise_pkg::PC_W-1:0]    pc,          // Program counter
  output logic                              nop_exec     // Squashed slot
);

  ////////////////////////////////////////////////////////////////
  // Architectural state
  logic [mise_pkg::DATA_W-1:0] accum_ff,  nxt_accum;   // Accumulator
  logic [mise_pkg::DATA_W-1:0] status_ff, nxt_status;  // Status flags
  logic [mise_pkg::DATA_W-1:0] option_ff, nxt_option;  // Option bits
  logic [mise_pkg::PC_W-1:0]   pc_ff,     nxt_pc;      // Program counter
  logic                        squash_ff, nxt_squash;  // Discard next
  logic                        nop_ff,    nxt_nop;     // Slot was squashed
  logic [mise_pkg::DATA_W-1:0] rdata_ff,  nxt_rdata;   // Read data

  // File register space
  logic [mise_pkg::DATA_W-1:0]  file_mem [mise_pkg::FILE_N]; // Storage
  logic                         file_we;                     // Write enable
  logic [mise_pkg::FADDR_W-1:0] file_waddr;                  // Write address
  logic [mise_pkg::DATA_W-1:0]  file_wdata;                  // Write data

  // Decoded fields
  mise_pkg::mise_op_e           op;        // Operation kind
  logic [mise_pkg::FADDR_W-1:0] fsel;      // File address
  logic [mise_pkg::BIT_W-1:0]   bsel;      // Bit index
  logic [mise_pkg::DATA_W-1:0]  lit;       // Immediate
  logic                         dest_file; // Result to file
  logic [mise_pkg::DATA_W-1:0]  fval;      // Addressed file value
  logic [mise_pkg::DATA_W-1:0]  result;    // Logic result
  logic                         tested;    // Selected bit

  // Neighbours
  logic                        stk_push;   // Stack push
  logic [mise_pkg::PC_W-1:0]   stk_addr;   // Pushed address
  logic [mise_pkg::PC_W-1:0]   stk_top;    // Stack top
  logic                        wd_kick;    // Watchdog kick
  logic [mise_pkg::DATA_W-1:0] wd_count;   // Watchdog count
  logic                        wd_expire;  // Watchdog overflow

  // Port decode helpers
  logic                        bus_file;   // Address in file window
  logic [mise_pkg::FADDR_W-1:0] bus_fsel;  // File index from port

  ////////////////////////////////////////////////////////////////
  // Field extraction
  always_comb begin
    op        = mise_pkg::mise_decode(instr_word);
    fsel      = instr_word[mise_pkg::FADDR_LSB +: mise_pkg::FADDR_W];
    bsel      = instr_word[mise_pkg::BIT_LSB +: mise_pkg::BIT_W];
    lit       = instr_word[mise_pkg::LIT_LSB +: mise_pkg::DATA_W];
    dest_file = instr_word[mise_pkg::DEST_POS];
    fval      = file_mem[fsel];
    tested    = fval[bsel];
    bus_file  = ((reg_addr & mise_pkg::FILE_MASK) == mise_pkg::FILE_BASE);
    bus_fsel  = reg_addr[mise_pkg::FADDR_W-1:0];
  end

  ////////////////////////////////////////////////////////////////
  // Execute next state
  always_comb begin
    nxt_accum  = accum_ff;
    nxt_status = status_ff;
    nxt_option = option_ff;
    nxt_pc     = pc_ff;
    nxt_squash = squash_ff;
    nxt_nop    = 1'b0;
    file_we    = 1'b0;
    file_waddr = bus_fsel;
    file_wdata = reg_wdata;
    stk_push   = 1'b0;
    stk_addr   = pc_ff + 11'h001;
    wd_kick    = 1'b0;
    result     = mise_pkg::ZERO8;

    // Software writes first; execution below overrides
    if (reg_wr) begin
      if (reg_addr == mise_pkg::REG_ACCUM) begin
        nxt_accum = reg_wdata;
      end else if (reg_addr == mise_pkg::REG_STATUS) begin
        nxt_status = reg_wdata;
      end else if (reg_addr == mise_pkg::REG_OPTION) begin
        nxt_option = reg_wdata;
      end else if (bus_file) begin
        file_we = 1'b1;
      end
    end

    // Watchdog overflow drops expiry flag
    if (wd_expire) begin
      nxt_status[mise_pkg::ST_EXPIRY] = 1'b0;
    end

    if (instr_valid) begin
      nxt_pc = pc_ff + 11'h001;
      if (squash_ff) begin
        // Prefetched word discarded, no-operation runs
        nxt_squash = 1'b0;
        nxt_nop    = 1'b1;
      end else begin
        unique case (op)
          mise_pkg::OP_AND: begin
            result = accum_ff & fval;
            nxt_status[mise_pkg::ST_NULL] = (result == mise_pkg::ZERO8);
            if (dest_file) begin
              file_we    = 1'b1;
              file_waddr = fsel;
              file_wdata = result;
            end else begin
              nxt_accum = result;
            end
          end
          mise_pkg::OP_INVERT: begin
            result = ~fval;
            nxt_status[mise_pkg::ST_NULL] = (result == mise_pkg::ZERO8);
            if (dest_file) begin
              file_we    = 1'b1;
              file_waddr = fsel;
              file_wdata = result;
            end else begin
              nxt_accum = result;
            end
          end
          mise_pkg::OP_CLEAR_FILE_REG: begin
            file_we    = 1'b1;
            file_waddr = fsel;
            file_wdata = mise_pkg::ZERO8;
            nxt_status[mise_pkg::ST_NULL] = 1'b1;
          end
          mise_pkg::OP_CLEAR_ACCUMULATOR: begin
            nxt_accum = mise_pkg::ZERO8;
            nxt_status[mise_pkg::ST_NULL] = 1'b1;
          end
          mise_pkg::OP_KICK: begin
            wd_kick = 1'b1;
            nxt_status[mise_pkg::ST_EXPIRY] = 1'b1;
            nxt_status[mise_pkg::ST_SLEEP]  = 1'b1;
          end
          mise_pkg::OP_BTC: begin
            // Flags untouched
            nxt_squash = ~tested;
          end
          mise_pkg::OP_BTS: begin
            // Flags untouched
            nxt_squash = tested;
          end
          mise_pkg::OP_CALL: begin
            stk_push   = 1'b1;
            nxt_pc     = {status_ff[mise_pkg::ST_PAGE_LSB +: mise_pkg::PAGE_W],
                          1'b0, lit};
            nxt_squash = 1'b1;
          end
          mise_pkg::OP_OTHER: begin
            // Outside the subset: plain advance
            nxt_squash = 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read port answer, one cycle after the strobe
  always_comb begin
    nxt_rdata = mise_pkg::ZERO8;
    if (reg_rd) begin
      if (bus_file) begin
        nxt_rdata = file_mem[bus_fsel];
      end else begin
        unique case (reg_addr)
          mise_pkg::REG_ACCUM:  nxt_rdata = accum_ff;
          mise_pkg::REG_STATUS: nxt_rdata = status_ff;
          mise_pkg::REG_OPTION: nxt_rdata = option_ff;
          mise_pkg::REG_PC_LO:  nxt_rdata = pc_ff[7:0];
          mise_pkg::REG_PC_HI:  nxt_rdata = {5'h00, pc_ff[10:8]};
          mise_pkg::REG_WDOG:   nxt_rdata = wd_count;
          mise_pkg::REG_STK_LO: nxt_rdata = stk_top[7:0];
          mise_pkg::REG_STK_HI: nxt_rdata = {5'h00, stk_top[10:8]};
          default:              nxt_rdata = mise_pkg::ZERO8;  // Unmapped reads zero
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Core registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      accum_ff  <= mise_pkg::ACCUM_RST;
      status_ff <= mise_pkg::STATUS_RST;
      option_ff <= mise_pkg::OPTION_RST;
      pc_ff     <= mise_pkg::PC_RST;
      squash_ff <= 1'b0;
      nop_ff    <= 1'b0;
      rdata_ff  <= mise_pkg::ZERO8;
    end else begin
      accum_ff  <= nxt_accum;
      status_ff <= nxt_status;
      option_ff <= nxt_option;
      pc_ff     <= nxt_pc;
      squash_ff <= nxt_squash;
      nop_ff    <= nxt_nop;
      rdata_ff  <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // File register storage, no reset
  always_ff @(posedge mclk) begin
    if (file_we) begin
      file_mem[file_waddr] <= file_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Hardware stack, return address pc + 1 pushed on the same edge the PC moves
  mise_stack u_stack (
    .mclk      (mclk),
    .rst       (rst),
    .push      (stk_push),
    .push_addr (stk_addr),
    .top       (stk_top)
  );

  // Watchdog with shared prescaler
  mise_wdog u_wdog (
    .mclk    (mclk),
    .rst     (rst),
    .kick    (wd_kick),
    .to_wdog (option_ff[mise_pkg::OPT_TO_WDOG]),
    .count   (wd_count),
    .expire  (wd_expire)
  );

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_ff;
  assign pc        = pc_ff;
  assign nop_exec  = nop_ff;

endmodule : mise_exec
`default_nettype wire

/* dv/mise_exec_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module mise_exec_chk (
  input wire logic        mclk,        // Clock
  input wire logic        rst,         // Sync reset
  input wire logic [11:0] instr_word,  // Executed word
  input wire logic        instr_valid, // Word present
  input wire logic [5:0]  reg_addr,    // Port address
  input wire logic [7:0]  reg_wdata,   // Port write data
  input wire logic        reg_wr,      // Write strobe
  input wire logic        reg_rd,      // Read strobe
  input wire logic [7:0]  reg_rdata,   // Read data
  input wire logic [10:0] pc,          // Program counter
  input wire logic        nop_exec     // Squash pulse
);
  ////////////////////////////////////////////////////////////////////////////////
  // Single clock domain
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Call word in the execute slot
  logic is_call;
  assign is_call = instr_valid && ((instr_word & mise_pkg::NIB_MASK) == mise_pkg::CALL_MATCH);

  ////////////////////////////////////////////////////////////////////////////////
  // Program counter
  a_pc_hold: assert property (!instr_valid |=> $stable(pc))
    else $error("pc moved without an instruction");
  a_pc_step: assert property (instr_valid && !is_call |=> pc == $past(pc) + 11'h001)
    else $error("pc did not step by one");
  a_call_target: assert property (is_call |=> nop_exec || (pc[7:0] == $past(instr_word[7:0]) && !pc[8]))
    else $error("call target wrong");
  a_call_slot: assert property (is_call ##1 (instr_valid && !nop_exec) |=> nop_exec)
    else $error("call did not squash the next slot");

  ////////////////////////////////////////////////////////////////////////////////
  // Squash pulse
  a_nop_pulse: assert property (nop_exec |=> !nop_exec)
    else $error("squash pulse longer than one cycle");
  a_nop_cause: assert property (nop_exec |-> $past(instr_valid))
    else $error("squash pulse without a slot");

  ////////////////////////////////////////////////////////////////////////////////
  // Register port
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_pclo_read: assert property (reg_rd && reg_addr == 6'h03 && !instr_valid |=> reg_rdata == pc[7:0])
    else $error("pc low read wrong");
  a_unmap_zero: assert property (reg_rd && reg_addr inside {[6'h08:6'h1F]} |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : mise_exec_chk

bind mise_exec mise_exec_chk u_chk (
  .mclk(mclk), .rst(rst), .instr_word(instr_word), .instr_valid(instr_valid), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc(pc), .nop_exec(nop_exec)
);
`default_nettype wire

/* dv/mise_exec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module mise_exec_tb;
  logic        mclk;            // Clock
  logic        rst;             // Sync reset
  logic [11:0] instr_word;      // Executed word
  logic        instr_valid;     // Word present
  logic [5:0]  reg_addr;        // Port address
  logic [7:0]  reg_wdata;       // Port write data
  logic        reg_wr;          // Write strobe
  logic        reg_rd;          // Read strobe
  logic [7:0]  reg_rdata;       // Read data
  logic [10:0] pc;              // Program counter
  logic        nop_exec;        // Squash pulse
  int          n_fail;          // Mismatches
  int          samples_checked; // Comparisons

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and device
  always #20 mclk = ~mclk;

  mise_exec u_dut (
    .mclk(mclk), .rst(rst), .instr_word(instr_word), .instr_valid(instr_valid), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc(pc), .nop_exec(nop_exec)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic rchk(input logic [5:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd(a, d);
    chk8(d, exp, what);
  endtask : rchk

  task automatic exec1(input logic [11:0] w);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge mclk);
    instr_valid <= 1'b0;
  endtask : exec1

  // Two back-to-back slots, squash pulse sampled after the second
  task automatic exec2(input logic [11:0] w1, input logic [11:0] w2, output logic n);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_word <= w1;
    @(posedge mclk);
    instr_word <= w2;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1 n = nop_exec;
  endtask : exec2

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    rchk(6'h01, 8'h18, "status reset");
    rchk(6'h02, 8'h08, "option reset");
    rchk(6'h00, 8'h00, "accum reset");
    rchk(6'h10, 8'h00, "unmapped read");
    $display("test reset done");
  endtask : t_reset

  task automatic t_and;
    wr(6'h00, 8'h0F);
    wr(6'h3F, 8'h3C);
    exec1(12'h15F);
    rchk(6'h00, 8'h0C, "and to accum");
    rchk(6'h01, 8'h18, "and nonzero flag");
    wr(6'h24, 8'hF0);
    exec1(12'h164);
    rchk(6'h24, 8'h00, "and to file");
    rchk(6'h00, 8'h0C, "and accum kept");
    rchk(6'h01, 8'h1C, "and zero flag");
    $display("test and done");
  endtask : t_and

  task automatic t_inv;
    wr(6'h25, 8'hFF);
    exec1(12'h245);
    rchk(6'h00, 8'h00, "invert to accum");
    rchk(6'h01, 8'h1C, "invert zero flag");
    wr(6'h3F, 8'h5A);
    exec1(12'h27F);
    rchk(6'h3F, 8'hA5, "invert to file");
    rchk(6'h01, 8'h18, "invert nonzero flag");
    $display("test invert done");
  endtask : t_inv

  task automatic t_clr;
    wr(6'h00, 8'h77);
    exec1(12'h040);
    rchk(6'h00, 8'h00, "clear accum");
    rchk(6'h01, 8'h1C, "clear accum flag");
    wr(6'h01, 8'h18);
    wr(6'h27, 8'h99);
    exec1(12'h067);
    rchk(6'h27, 8'h00, "clear file");
    rchk(6'h01, 8'h1C, "clear file flag");
    $display("test clear done");
  endtask : t_clr

  // Both bit tests over every bit index, next slot clears the accumulator
  task automatic t_skip;
    logic [2:0] b;
    logic       set;
    logic       skip;
    logic       n;
    wr(6'h29, 8'hA5);
    for (int i = 0; i < 16; i++) begin
      b = i[2:0];
      set = i[3];
      skip = set ? 8'hA5 >> b & 8'h01 : !(8'hA5 >> b & 8'h01);
      wr(6'h00, 8'h55);
      wr(6'h01, 8'h18);
      exec2({set ? 4'h7 : 4'h6, b, 5'h09}, 12'h040, n);
      chk8({7'h00, n}, {7'h00, skip}, "skip pulse");
      rchk(6'h00, skip ? 8'h55 : 8'h00, "skipped slot");
      rchk(6'h01, skip ? 8'h18 : 8'h1C, "test flags");
    end
    $display("test skip done");
  endtask : t_skip

  task automatic t_call;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [10:0] ret;
    logic        n;
    rd(6'h03, lo);
    rd(6'h04, hi);
    ret = {hi[2:0], lo} + 11'h001;
    wr(6'h00, 8'h33);
    wr(6'h01, 8'h58);
    exec2(12'h9FF, 12'h040, n);
    chk8({7'h00, n}, 8'h01, "call squash");
    rchk(6'h00, 8'h33, "call slot discarded");
    rchk(6'h03, 8'h00, "call pc low");
    rchk(6'h04, 8'h05, "call pc high");
    rchk(6'h06, ret[7:0], "return low");
    rchk(6'h07, {5'h00, ret[10:8]}, "return high");
    rchk(6'h01, 8'h58, "call flags");
    $display("test call done");
  endtask : t_call

  // Kick 150 cycles after a count step, then wait 150 cycles, short of a full prescaler span
  task automatic t_kick;
    logic [7:0] c0;
    logic [7:0] d;
    int         k;
    wr(6'h01, 8'h00);
    rd(6'h05, c0);
    k = 0;
    do begin
      rd(6'h05, d);
      k++;
    end while (d === c0 && k < 300);
    chk8({7'h00, k < 300}, 8'h01, "count step seen");
    repeat (150) @(posedge mclk);
    exec1(12'h004);
    rchk(6'h05, 8'h00, "kick count");
    rchk(6'h01, 8'h18, "kick flags");
    repeat (150) @(posedge mclk);
    rchk(6'h05, 8'h00, "kick prescaler");
    $display("test kick done");
  endtask : t_kick

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    instr_word = 12'h000;
    instr_valid = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_and;
    t_inv;
    t_clr;
    t_skip;
    t_call;
    t_kick;
    conclude;
  end

  // Hang guard
  initial begin
    #2000000;
    n_fail++;
    $display("[ERR] %0t run timeout", $time);
    conclude;
  end
endmodule : mise_exec_tb
`default_nettype wire
